// >>> src/pmcs_pkg.sv
// Package of constants for the power, mode and clock supervisor.
// Assumes a single 40 MHz system clock and synchronous active-low reset.
package pmcs_pkg;

    // =========================================================================
    // Timing
    // =========================================================================
    localparam int unsigned CLK_HZ            = 40_000_000;
    // Wait for the external oscillator to settle, in microseconds.
    localparam int unsigned EXT_SETTLE_US     = 100;
    localparam int unsigned EXT_SETTLE_CYC    =
        (EXT_SETTLE_US * (CLK_HZ / 1_000_000) > 0) ?
        EXT_SETTLE_US * (CLK_HZ / 1_000_000) : 1;
    // Longest gap between external clock edges before failure, in ns.
    localparam int unsigned EXT_FAIL_NS       = 1000;
    localparam int unsigned EXT_FAIL_CYC      =
        (EXT_FAIL_NS * (CLK_HZ / 1_000_000) / 1000 > 0) ?
        EXT_FAIL_NS * (CLK_HZ / 1_000_000) / 1000 : 1;
    localparam int unsigned RESET_HOLD_CYC    = 16;
    localparam int unsigned CNT_W             = 16;

    // =========================================================================
    // Encodings
    // =========================================================================
    localparam logic [1:0] BOOT_USER_FLASH   = 2'h0;
    localparam logic [1:0] BOOT_SYSTEM_MEM   = 2'h1;
    localparam logic [1:0] BOOT_SRAM         = 2'h2;
    localparam logic [1:0] CLK_SEL_INT_RC    = 2'h0;
    localparam logic [1:0] CLK_SEL_EXT       = 2'h1;
    localparam int unsigned EXT_LINES        = 16;

    typedef enum logic [2:0] {
        ST_RESET, ST_RUN, ST_SLEEP, ST_STOP, ST_STANDBY
    } pwr_state_e;

    // Boot pins and option bit to boot source.
    function automatic logic [1:0] boot_decode(input logic pin0,
                                               input logic pin1,
                                               input logic opt);
        if (!pin0) begin
            boot_decode = BOOT_USER_FLASH;
        end else if (pin1 ^ opt) begin
            boot_decode = BOOT_SRAM;
        end else begin
            boot_decode = BOOT_SYSTEM_MEM;
        end
    endfunction : boot_decode

endpackage : pmcs_pkg

// >>> src/power_mode_clock_supervisor.sv
// Reset, supply monitoring, low-power mode sequencing and clock selection.
// Assumes analog comparators and wake sources arrive asynchronously as pins.
// Core reset output is active low; oscillator enables are active high.

// Contract
// - Hold reset while supply below threshold.
// - Threshold crossing either way raises interrupt.
// - Threshold detector idle until software enables.
// - Regulator enabled in main mode after reset.
// - Standby floats regulator, core loses power.
// - Sleep halts CPU; any interrupt wakes.
// - Stop gates clocks, oscillators off, retains state.
// - Stop regulator mode chosen by software.
// - Stop exits on enabled external line or RTC.
// - Standby powers core off, oscillators off.
// - Standby exits on reset, watchdog, wake, RTC.
// - RTC and watchdog clocks never stop.
// - Reset selects internal RC clock.
// - External clock failure falls back to RC.
// - Enabled clock failure raises interrupt.
// - Sample boot pins and option at startup.
module power_mode_clock_supervisor
    import pmcs_pkg::*;
#(
    parameter int unsigned SETTLE_CYC = EXT_SETTLE_CYC
) (
    input  wire logic                 clk,
    input  wire logic                 reset_n,
    input  wire logic                 supply_below_reset,
    input  wire logic                 supply_below_threshold,
    input  wire logic                 external_reset_pin_n,
    input  wire logic                 independent_watchdog_reset,
    input  wire logic                 wake_pin,
    input  wire logic                 rtc_event,
    input  wire logic [EXT_LINES-1:0] external_interrupt_lines,
    input  wire logic [EXT_LINES-1:0] stop_wake_mask,
    input  wire logic                 rtc_wake_enable,
    input  wire logic                 any_interrupt,
    input  wire logic                 detector_enable,
    input  wire logic                 detector_irq_clear,
    input  wire logic                 sleep_request,
    input  wire logic                 stop_request,
    input  wire logic                 standby_request,
    input  wire logic                 stop_lowpower_select,
    input  wire logic                 ext_clock_request,
    input  wire logic                 ext_clock_tick,
    input  wire logic                 clock_fail_irq_enable,
    input  wire logic                 clock_fail_irq_clear,
    input  wire logic                 boot_pin0,
    input  wire logic                 boot_pin1,
    input  wire logic                 boot_option,
    output logic                      core_reset_n,
    output logic                      cpu_clock_enable,
    output logic                      core_clock_enable,
    output logic                      core_power_enable,
    output logic                      regulator_enable,
    output logic                      regulator_main_mode,
    output logic                      regulator_lowpower_mode,
    output logic                      regulator_output_hiz,
    output logic                      internal_fast_rc_osc_en,
    output logic                      external_crystal_osc_en,
    output logic                      pll_enable,
    output logic                      always_on_clock_enable,
    output logic [1:0]                system_clock_select,
    output logic [1:0]                boot_source,
    output logic                      detector_irq,
    output logic                      supply_above_level,
    output logic                      clock_fail_irq,
    output logic                      clock_fail_flag
);

    // =========================================================================
    // Pin synchronisers
    // =========================================================================
    localparam int unsigned NSYNC = 8 + EXT_LINES;
    localparam logic [NSYNC-1:0] SYNC_IDLE = {{EXT_LINES{1'b0}}, 8'h20};
    logic [NSYNC-1:0] raw;
    logic [NSYNC-1:0] s1_q, s2_q, s3_q, filt_q;

    assign raw = {external_interrupt_lines, supply_below_reset,
                  supply_below_threshold, external_reset_pin_n,
                  independent_watchdog_reset, wake_pin, rtc_event,
                  ext_clock_tick, 1'b0};

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            s1_q <= SYNC_IDLE;
            s2_q <= SYNC_IDLE;
            s3_q <= SYNC_IDLE;
        end else begin
            s1_q <= raw;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // A change is accepted once the second and third stages agree.
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            filt_q <= SYNC_IDLE;
        end else begin
            for (int i = 0; i < NSYNC; i++) begin
                if (s2_q[i] == s3_q[i]) begin
                    filt_q[i] <= s3_q[i];
                end
            end
        end
    end

    logic [EXT_LINES-1:0] lines_f;
    logic low_supply, thr_below, pin_rst_n, wdg_rst, wake_f, rtc_f, tick_f;
    assign lines_f    = filt_q[NSYNC-1:8];
    assign low_supply = filt_q[7];
    assign thr_below  = filt_q[6];
    assign pin_rst_n  = filt_q[5];
    assign wdg_rst    = filt_q[4];
    assign wake_f     = filt_q[3];
    assign rtc_f      = filt_q[2];
    assign tick_f     = filt_q[1];

    logic wake_prev_q, tick_prev_q, thr_prev_q;
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            wake_prev_q <= 1'b0;
            tick_prev_q <= 1'b0;
            thr_prev_q  <= 1'b0;
        end else begin
            wake_prev_q <= wake_f;
            tick_prev_q <= tick_f;
            thr_prev_q  <= thr_below;
        end
    end

    // =========================================================================
    // Reset and power state machine
    // =========================================================================
    pwr_state_e state_q;
    logic [CNT_W-1:0] hold_q;
    logic hard_reset, wake_stop, wake_standby;

    assign hard_reset = low_supply || !pin_rst_n || wdg_rst;
    assign wake_stop = |(lines_f & stop_wake_mask) || (rtc_wake_enable && rtc_f);
    assign wake_standby = (wake_f && !wake_prev_q) || rtc_f;

    always_ff @(posedge clk) begin
        if (!reset_n || hard_reset) begin
            state_q <= ST_RESET;
            hold_q  <= '0;
        end else begin
            case (state_q)
                ST_RESET: begin
                    if (hold_q == CNT_W'(RESET_HOLD_CYC - 1)) begin
                        state_q <= ST_RUN;
                    end else begin
                        hold_q <= hold_q + 1'b1;
                    end
                end
                ST_RUN: begin
                    if (standby_request) begin
                        state_q <= ST_STANDBY;
                    end else if (stop_request) begin
                        state_q <= ST_STOP;
                    end else if (sleep_request) begin
                        state_q <= ST_SLEEP;
                    end
                end
                ST_SLEEP: begin
                    if (any_interrupt) begin
                        state_q <= ST_RUN;
                    end
                end
                ST_STOP: begin
                    if (wake_stop) begin
                        state_q <= ST_RUN;
                    end
                end
                ST_STANDBY: begin
                    if (wake_standby) begin
                        state_q <= ST_RESET;
                        hold_q  <= '0;
                    end
                end
                default: state_q <= ST_RESET;
            endcase
        end
    end

    // =========================================================================
    // Power, regulator and oscillator controls
    // =========================================================================
    logic in_stop, in_standby, in_reset, low_osc;
    assign in_stop    = (state_q == ST_STOP);
    assign in_standby = (state_q == ST_STANDBY);
    assign in_reset   = (state_q == ST_RESET);
    assign low_osc    = in_stop || in_standby;

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            core_reset_n            <= 1'b0;
            cpu_clock_enable        <= 1'b0;
            core_clock_enable       <= 1'b0;
            core_power_enable       <= 1'b1;
            regulator_enable        <= 1'b1;
            regulator_main_mode     <= 1'b1;
            regulator_lowpower_mode <= 1'b0;
            regulator_output_hiz    <= 1'b0;
            internal_fast_rc_osc_en <= 1'b1;
            pll_enable              <= 1'b0;
            always_on_clock_enable  <= 1'b1;
        end else begin
            core_reset_n            <= !in_reset && !in_standby && !hard_reset;
            cpu_clock_enable        <= (state_q == ST_RUN);
            core_clock_enable       <= !low_osc;
            core_power_enable       <= !in_standby;
            regulator_enable        <= !in_standby;
            regulator_main_mode     <= !in_standby &&
                                       !(in_stop && stop_lowpower_select);
            regulator_lowpower_mode <= in_stop && stop_lowpower_select;
            regulator_output_hiz    <= in_standby;
            internal_fast_rc_osc_en <= !low_osc;
            pll_enable              <= 1'b0;
            always_on_clock_enable  <= 1'b1;
        end
    end

    // =========================================================================
    // Boot source capture
    // =========================================================================
    // sample boot straps
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            boot_source <= BOOT_USER_FLASH;
        end else if (in_reset) begin
            boot_source <= boot_decode(boot_pin0, boot_pin1, boot_option);
        end
    end

    // =========================================================================
    // Supply threshold detector
    // =========================================================================
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            detector_irq       <= 1'b0;
            supply_above_level <= 1'b0;
        end else if (!detector_enable) begin
            detector_irq       <= 1'b0;
            supply_above_level <= 1'b0;
        end else begin
            supply_above_level <= !thr_below;
            if (thr_below != thr_prev_q) begin
                detector_irq <= 1'b1;
            end else if (detector_irq_clear) begin
                detector_irq <= 1'b0;
            end
        end
    end

    // =========================================================================
    // Clock selection and external clock monitor
    // =========================================================================
    logic [CNT_W-1:0] settle_q, gap_q;
    logic ext_ok_q, fail_evt;
    assign fail_evt = (system_clock_select == CLK_SEL_EXT) &&
                      (gap_q >= CNT_W'(EXT_FAIL_CYC));

    always_ff @(posedge clk) begin
        if (!reset_n || in_reset) begin
            gap_q <= '0;
        end else if (tick_f != tick_prev_q || !external_crystal_osc_en) begin
            gap_q <= '0;
        end else if (gap_q != '1) begin
            gap_q <= gap_q + 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n || in_reset) begin
            system_clock_select     <= CLK_SEL_INT_RC;
            external_crystal_osc_en <= 1'b0;
            settle_q                <= '0;
            ext_ok_q                <= 1'b0;
        end else if (low_osc || fail_evt || !ext_clock_request) begin
            system_clock_select     <= CLK_SEL_INT_RC;
            external_crystal_osc_en <= ext_clock_request && !low_osc &&
                                       !fail_evt;
            settle_q                <= '0;
            ext_ok_q                <= 1'b0;
        end else begin
            external_crystal_osc_en <= 1'b1;
            if (settle_q == CNT_W'(SETTLE_CYC - 1)) begin
                ext_ok_q <= 1'b1;
            end else begin
                settle_q <= settle_q + 1'b1;
            end
            if (ext_ok_q && !clock_fail_flag) begin
                system_clock_select <= CLK_SEL_EXT;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n || in_reset) begin
            clock_fail_flag <= 1'b0;
            clock_fail_irq  <= 1'b0;
        end else begin
            if (fail_evt) begin
                clock_fail_flag <= 1'b1;
            end else if (clock_fail_irq_clear) begin
                clock_fail_flag <= 1'b0;
            end
            if (fail_evt && clock_fail_irq_enable) begin
                clock_fail_irq <= 1'b1;
            end else if (clock_fail_irq_clear) begin
                clock_fail_irq <= 1'b0;
            end
        end
    end

endmodule : power_mode_clock_supervisor

// >>> dv/power_mode_clock_supervisor_chk.sv
// Concurrent checks on the supervisor's top-level ports.
// Assumes one clock and the block's synchronous active-low reset.
module power_mode_clock_supervisor_chk
    import pmcs_pkg::*;
(
    input logic       clk,
    input logic       reset_n,
    input logic       supply_below_reset,
    input logic       supply_below_threshold,
    input logic       wake_pin,
    input logic       detector_enable,
    input logic       clock_fail_irq_enable,
    input logic       core_reset_n,
    input logic       core_clock_enable,
    input logic       core_power_enable,
    input logic       regulator_enable,
    input logic       regulator_output_hiz,
    input logic       internal_fast_rc_osc_en,
    input logic       external_crystal_osc_en,
    input logic       pll_enable,
    input logic       always_on_clock_enable,
    input logic [1:0] system_clock_select,
    input logic       detector_irq,
    input logic       clock_fail_irq,
    input logic       clock_fail_flag
);
    timeunit 1ns;
    timeprecision 100ps;
    // =================================================================
    // Properties
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    property p_pdr_hold;
        supply_below_reset [*8] |-> !core_reset_n;
    endproperty
    a_pdr_hold: assert property (p_pdr_hold)
        else $error("core left running on low supply");
    property p_reset_up;
        $rose(core_reset_n) |->
            regulator_enable && system_clock_select == CLK_SEL_INT_RC;
    endproperty
    a_reset_up: assert property (p_reset_up)
        else $error("wrong regulator or clock after reset");
    property p_det_off;
        !detector_enable [*2] |-> !detector_irq;
    endproperty
    a_det_off: assert property (p_det_off)
        else $error("detector interrupt while disabled");
    property p_det_irq;
        detector_enable && $changed(supply_below_threshold) |->
            ##[1:6] detector_irq;
    endproperty
    a_det_irq: assert property (p_det_irq)
        else $error("no detector interrupt on crossing");
    property p_standby_off;
        regulator_output_hiz |-> !core_power_enable &&
            !internal_fast_rc_osc_en && !external_crystal_osc_en;
    endproperty
    a_standby_off: assert property (p_standby_off)
        else $error("core or oscillator on in standby");
    property p_stop_osc;
        core_reset_n && $past(core_reset_n) && !core_clock_enable |->
            !internal_fast_rc_osc_en && !external_crystal_osc_en &&
            !pll_enable;
    endproperty
    a_stop_osc: assert property (p_stop_osc)
        else $error("oscillator running with core clock gated");
    property p_standby_wake;
        regulator_output_hiz && $rose(wake_pin) |->
            ##[1:40] !regulator_output_hiz;
    endproperty
    a_standby_wake: assert property (p_standby_wake)
        else $error("wake pin did not end standby");
    property p_always_on;
        regulator_output_hiz || !core_clock_enable |->
            always_on_clock_enable;
    endproperty
    a_always_on: assert property (p_always_on)
        else $error("always-on clock stopped");
    property p_fail_rc;
        clock_fail_flag [*3] |-> system_clock_select == CLK_SEL_INT_RC;
    endproperty
    a_fail_rc: assert property (p_fail_rc)
        else $error("external clock kept after failure");
    property p_fail_irq;
        $rose(clock_fail_flag) && clock_fail_irq_enable |->
            ##[0:1] clock_fail_irq;
    endproperty
    a_fail_irq: assert property (p_fail_irq)
        else $error("no clock failure interrupt");

    c_standby: cover property (regulator_output_hiz);
    c_ext: cover property (system_clock_select == CLK_SEL_EXT);
    c_fail: cover property ($rose(clock_fail_flag));
endmodule : power_mode_clock_supervisor_chk

bind power_mode_clock_supervisor power_mode_clock_supervisor_chk i_chk (.*);

// >>> dv/power_mode_clock_supervisor_tb_top.sv
// Directed bench for the power, mode and clock supervisor.
// Assumes the checker is bound from its own file.
module power_mode_clock_supervisor_tb_top
    import pmcs_pkg::*;
();
    timeunit 1ns;
    timeprecision 100ps;
    // =================================================================
    // Signals
    logic clk = 1'h0, reset_n = 1'h0, supply_below_reset = 1'h0;
    logic supply_below_threshold = 1'h0, wake_pin = 1'h0, rtc_event = 1'h0;
    logic external_reset_pin_n = 1'h1, independent_watchdog_reset = 1'h0;
    logic rtc_wake_enable = 1'h0, any_interrupt = 1'h0, tick_on = 1'h0;
    logic detector_enable = 1'h0, detector_irq_clear = 1'h0;
    logic sleep_request = 1'h0, stop_request = 1'h0, boot_option = 1'h0;
    logic standby_request = 1'h0, stop_lowpower_select = 1'h0;
    logic ext_clock_request = 1'h0, ext_clock_tick = 1'h0;
    logic clock_fail_irq_enable = 1'h0, clock_fail_irq_clear = 1'h0;
    logic boot_pin0 = 1'h0, boot_pin1 = 1'h0;
    logic [EXT_LINES-1:0] external_interrupt_lines = 16'h0000;
    logic [EXT_LINES-1:0] stop_wake_mask = 16'h0000;
    logic [1:0] tcnt = 2'h0, system_clock_select, boot_source;
    logic core_reset_n, cpu_clock_enable, core_clock_enable, pll_enable;
    logic core_power_enable, regulator_enable, regulator_main_mode;
    logic regulator_lowpower_mode, regulator_output_hiz;
    logic internal_fast_rc_osc_en, external_crystal_osc_en;
    logic always_on_clock_enable, detector_irq, supply_above_level;
    logic clock_fail_irq, clock_fail_flag;
    int   error_cnt, n_tests, cycles;

    power_mode_clock_supervisor #(.SETTLE_CYC(20)) i_dut (.*);

    always #12.5 clk = !clk;
    always @(posedge clk) begin
        tcnt <= tcnt + 2'h1;
        if (tick_on && tcnt == 2'h3) begin
            ext_clock_tick <= !ext_clock_tick;
        end
        cycles <= cycles + 1;
        if (cycles == 4000) begin
            error_cnt++;
            give_verdict();
        end
    end
    // =================================================================
    // Tasks
    task automatic give_verdict;
        if (error_cnt == 0 && n_tests > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : give_verdict
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask : cyc
    task automatic chk(input string nm, input logic [1:0] e,
                       input logic [1:0] g);
        n_tests++;
        if (g !== e) begin
            error_cnt++;
            $display("unexpected %s: expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic up;
        cyc(1);
        for (int i = 0; i < 80 && core_reset_n !== 1'h1; i++) cyc(1);
        chk("core_reset_n", 1'h1, core_reset_n);
        chk("clock_select", CLK_SEL_INT_RC, system_clock_select);
    endtask : up
    task automatic rst(input logic [2:0] s);
        logic [1:0] e;
        e = !s[2] ? BOOT_USER_FLASH : (s[1] ^ s[0]) ? BOOT_SRAM :
            BOOT_SYSTEM_MEM;
        reset_n <= 1'h0;
        {boot_pin0, boot_pin1, boot_option} <= s;
        cyc(4);
        reset_n <= 1'h1;
        up();
        chk("boot_source", e, boot_source);
    endtask : rst
    // =================================================================
    // Sequence
    initial begin
        cyc(16);
        reset_n <= 1'h1;
        up();
        chk("regulator_enable", 1'h1, regulator_enable);
        chk("main_mode", 1'h1, regulator_main_mode);
        for (int s = 0; s < 8; s++) rst(3'(s));
        supply_below_reset <= 1'h1;
        cyc(10);
        chk("core_reset_n", 1'h0, core_reset_n);
        supply_below_reset <= 1'h0;
        up();
        supply_below_threshold <= 1'h1;
        cyc(10);
        chk("detector_irq", 1'h0, detector_irq);
        detector_enable <= 1'h1;
        cyc(3);
        supply_below_threshold <= 1'h0;
        cyc(10);
        chk("detector_irq", 1'h1, detector_irq);
        chk("above_level", 1'h1, supply_above_level);
        detector_irq_clear <= 1'h1;
        cyc(1);
        detector_irq_clear <= 1'h0;
        cyc(2);
        chk("detector_irq", 1'h0, detector_irq);
        supply_below_threshold <= 1'h1;
        cyc(10);
        chk("detector_irq", 1'h1, detector_irq);
        detector_enable <= 1'h0;
        cyc(3);
        chk("detector_irq", 1'h0, detector_irq);
        sleep_request <= 1'h1;
        cyc(1);
        sleep_request <= 1'h0;
        cyc(4);
        chk("cpu_clock", 1'h0, cpu_clock_enable);
        chk("core_clock", 1'h1, core_clock_enable);
        any_interrupt <= 1'h1;
        cyc(4);
        chk("cpu_clock", 1'h1, cpu_clock_enable);
        any_interrupt <= 1'h0;
        // stop, first by line then by timer.
        for (int k = 0; k < 2; k++) begin
            stop_lowpower_select <= k[0];
            stop_request <= 1'h1;
            cyc(1);
            stop_request <= 1'h0;
            cyc(4);
            chk("core_clock", 1'h0, core_clock_enable);
            chk("rc_osc", 1'h0, internal_fast_rc_osc_en);
            chk("lowpower", k[0], regulator_lowpower_mode);
            chk("main_mode", !k[0], regulator_main_mode);
            external_interrupt_lines <= k[0] ? 16'h0000 : 16'h8000;
            rtc_event <= k[0];
            stop_wake_mask <= 16'h0001;
            cyc(10);
            chk("core_clock", 1'h0, core_clock_enable);
            stop_wake_mask <= 16'h8001;
            rtc_wake_enable <= 1'h1;
            cyc(10);
            chk("core_clock", 1'h1, core_clock_enable);
            {rtc_event, rtc_wake_enable} <= 2'h0;
            external_interrupt_lines <= 16'h0000;
            cyc(4);
        end
        // standby, each wake source in turn.
        {boot_pin0, boot_pin1, boot_option} <= 3'h6;
        for (int k = 0; k < 4; k++) begin
            standby_request <= 1'h1;
            stop_request <= (k == 0);
            cyc(1);
            standby_request <= 1'h0;
            stop_request <= 1'h0;
            cyc(4);
            chk("hiz", 1'h1, regulator_output_hiz);
            chk("power", 1'h0, core_power_enable);
            chk("rc_osc", 1'h0, internal_fast_rc_osc_en);
            chk("always_on", 1'h1, always_on_clock_enable);
            wake_pin <= (k == 0);
            rtc_event <= (k == 1);
            external_reset_pin_n <= (k != 2);
            independent_watchdog_reset <= (k == 3);
            cyc(6);
            {wake_pin, rtc_event, independent_watchdog_reset} <= 3'h0;
            external_reset_pin_n <= 1'h1;
            up();
            chk("hiz", 1'h0, regulator_output_hiz);
            chk("boot_source", BOOT_SRAM, boot_source);
        end
        // clock loss, interrupt on then off.
        for (int k = 0; k < 2; k++) begin
            clock_fail_irq_enable <= !k[0];
            ext_clock_request <= 1'h1;
            tick_on <= 1'h1;
            for (int i = 0; i < 200 && system_clock_select !==
                 CLK_SEL_EXT; i++) cyc(1);
            chk("clock_select", CLK_SEL_EXT, system_clock_select);
            tick_on <= 1'h0;
            cyc(60);
            chk("clock_select", CLK_SEL_INT_RC, system_clock_select);
            chk("fail_flag", 1'h1, clock_fail_flag);
            chk("fail_irq", !k[0], clock_fail_irq);
            ext_clock_request <= 1'h0;
            clock_fail_irq_clear <= 1'h1;
            cyc(1);
            clock_fail_irq_clear <= 1'h0;
            cyc(2);
            chk("fail_flag", 1'h0, clock_fail_flag);
        end
        give_verdict();
    end
endmodule : power_mode_clock_supervisor_tb_top
